// [fcdma_channel_ctrl.sv]
// Notes on behaviour
// - Dual mode: device address 24 bits, stepped
// - Continue block end: next address to memory address
// - Counter decrements per unit; zero means 64k
// - Continue block end: next count to counter, next count zeroed
// - Direction bit: 0 increment, 1 decrement
// - Memory space bits drive status during cycles
// - Class field selects mode; 010/011 reserved
// - Port size: 0 sixteen bit, 1 eight bit
// - Operand size counts only dual, 16-bit port
// - Request sense: 0 level, 1 edge
// - Bus mode 1 cycle steal, else obedient/burst
// - Direction: 0 memory to device, 1 reverse
// - Block flag sets unless done; read-then-access clears
// - Enabled flags raise channel interrupt request
// - Done flag on last count or completion input
// - Device step: 00 inc, 01 dec, 10 hold
// - Device space output, copied at continue end
// - Bus error flag set; write one clears
// - Enable/successive change only with write-enable one
// - Enable starts or permits; clearing pauses channel
// - Successive bit allows following continue blocks
// - Master set with enables unless error; cleared
// - Memory address 24 bits, step one or two
// - Enable clears when the counter runs out, unless a continue block follows
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`include "fcdma_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module fcdma_channel_ctrl #(
  parameter int NUM_CH = 4,
  parameter int ADDR_BITS = 24
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Transfer sequencer events
  input wire logic [NUM_CH-1:0] i_xfer_pulse,
  input wire logic [NUM_CH-1:0] i_done_pulse,
  input wire logic [1:0] i_act_ch,
  input wire logic i_dma_cycle,
  input wire logic i_dev_cycle,
  input wire logic i_bus_err,
  input wire logic i_nmi,
  // Channel state towards the sequencer
  output logic [NUM_CH-1:0] o_chan_run,
  output logic [NUM_CH-1:0] o_auto_req,
  output logic [NUM_CH-1:0] o_irq,
  output logic [1:0] o_space_status,
  output logic [ADDR_BITS-1:0] o_mem_addr,
  output logic [ADDR_BITS-1:0] o_dev_addr,
  output var fcdma_pkg::fcdma_ctrl_a_t o_act_cfg
);
  import fcdma_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [ADDR_BITS-1:0] mem_addr_q [NUM_CH];
  logic [ADDR_BITS-1:0] mem_addr_d [NUM_CH];
  logic [ADDR_BITS-1:0] dev_addr_q [NUM_CH];
  logic [ADDR_BITS-1:0] dev_addr_d [NUM_CH];
  logic [15:0] cnt_q [NUM_CH];
  logic [15:0] cnt_d [NUM_CH];
  logic [15:0] ncnt_q [NUM_CH];
  logic [15:0] ncnt_d [NUM_CH];
  fcdma_ctrl_a_t ca_q [NUM_CH];
  fcdma_ctrl_a_t ca_d [NUM_CH];
  fcdma_ctrl_b_t cb_q [NUM_CH];
  fcdma_ctrl_b_t cb_d [NUM_CH];
  logic [NUM_CH-1:0] en_q, en_d;
  logic [NUM_CH-1:0] suc_q, suc_d;
  logic [NUM_CH-1:0] arm_xfer_q, arm_xfer_d;
  logic [NUM_CH-1:0] arm_blk_q, arm_blk_d;
  logic master_q, master_d;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;

  // Output registers
  logic [31:0] hrdata_d;
  logic [NUM_CH-1:0] run_d, auto_d, irq_d;
  logic [1:0] space_d;
  logic [ADDR_BITS-1:0] mem_out_d, dev_out_d;
  fcdma_ctrl_a_t cfg_d;

  // Bus decode
  logic acc, rd_acc;
  logic [1:0] a_ch, w_ch;
  logic [4:0] a_reg, w_reg;
  logic a_is_ch, w_is_ch, w_is_opc;

  // --------------------------------------------------------------------------
  // AHB address and data phase decode
  // --------------------------------------------------------------------------
  // Only whole-word single transfers are used, so size is not decoded.
  // Ready is part of the qualifier so a phase is never taken twice should
  // another slave on the bus hold the transfer off.
  assign acc = i_hsel & i_htrans[`FCDMA_HTRANS_ACTIVE_BIT] & i_hready;
  assign rd_acc = acc & ~i_hwrite;
  assign a_ch = i_haddr[6:5];
  assign a_reg = i_haddr[4:0];
  assign a_is_ch = ~i_haddr[`FCDMA_CH_ADDR_BIT];
  assign w_ch = wr_addr_q[6:5];
  assign w_reg = wr_addr_q[4:0];
  assign w_is_ch = ~wr_addr_q[`FCDMA_CH_ADDR_BIT];
  assign w_is_opc = (wr_addr_q == `FCDMA_OPC_ADDR);

  // --------------------------------------------------------------------------
  // Next state of all channels
  // --------------------------------------------------------------------------
  // Software effects come first, hardware events last, so a flag that
  // hardware sets in the cycle software clears it is never lost.
  always_comb begin
    logic dual;
    logic cont;
    logic wide;
    logic sel_w;
    logic sel_a;
    logic [ADDR_BITS-1:0] step;
    fcdma_ctrl_a_t wca;
    logic any_start;
    dual = 1'b0;
    cont = 1'b0;
    wide = 1'b0;
    sel_w = 1'b0;
    sel_a = 1'b0;
    step = `FCDMA_STEP_WORD;
    wca = fcdma_ctrl_a_t'(i_hwdata[15:0]);
    any_start = 1'b0;
    wr_pend_d = acc & i_hwrite;
    wr_addr_d = i_haddr[7:0];
    en_d = en_q;
    suc_d = suc_q;
    arm_xfer_d = arm_xfer_q;
    arm_blk_d = arm_blk_q;
    master_d = master_q;
    for (int c = 0; c < NUM_CH; c++) begin
      mem_addr_d[c] = mem_addr_q[c];
      dev_addr_d[c] = dev_addr_q[c];
      cnt_d[c] = cnt_q[c];
      ncnt_d[c] = ncnt_q[c];
      ca_d[c] = ca_q[c];
      cb_d[c] = cb_q[c];
      dual = ca_q[c].device_class[2];
      cont = (ca_q[c].device_class == `FCDMA_CLS_SINGLE_CONT);
      // Byte units on an 8-bit port, or byte operands in dual mode only
      wide = ~ca_q[c].port_size_sel & ~(dual & ca_q[c].operand_size_sel);
      step = wide ? `FCDMA_STEP_WORD : `FCDMA_STEP_BYTE;
      sel_w = wr_pend_q & w_is_ch & (w_ch == 2'(c));
      sel_a = acc & a_is_ch & (a_ch == 2'(c));
      // Data phase register writes; the done flags are not writable
      if (sel_w) begin
        unique case (w_reg)
          `FCDMA_REG_MEM: mem_addr_d[c] = i_hwdata[ADDR_BITS-1:0];
          `FCDMA_REG_DEV: dev_addr_d[c] = i_hwdata[ADDR_BITS-1:0];
          `FCDMA_REG_CNT: cnt_d[c] = i_hwdata[15:0];
          `FCDMA_REG_NCNT: ncnt_d[c] = i_hwdata[15:0];
          `FCDMA_REG_CA: begin
            wca = fcdma_ctrl_a_t'(i_hwdata[15:0]);
            wca.xfer_done_flag = ca_q[c].xfer_done_flag;
            wca.block_done_flag = ca_q[c].block_done_flag;
            ca_d[c] = wca;
          end
          `FCDMA_REG_CB: begin
            cb_d[c].dev_addr_step = i_hwdata[1:0];
            cb_d[c].dev_space = i_hwdata[3:2];
            // Writing one clears, writing zero leaves it alone
            if (i_hwdata[`FCDMA_CB_ERR_BIT]) begin
              cb_d[c].dma_bus_error_flag = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      // Read of control A arms the two flag-clearing sequences. The arm
      // outlives other accesses in between, so software should read control A
      // right before the clearing access rather than rely on an old arm.
      if (sel_a && rd_acc && (a_reg == `FCDMA_REG_CA)) begin
        arm_xfer_d[c] = 1'b1;
        arm_blk_d[c] = 1'b1;
      end
      if (sel_a && rd_acc && (a_reg == `FCDMA_REG_CNT) && arm_xfer_q[c]) begin
        ca_d[c].xfer_done_flag = 1'b0;
        arm_xfer_d[c] = 1'b0;
      end
      // Any access to the next count completes the block flag clear
      if (sel_a && (a_reg == `FCDMA_REG_NCNT) && arm_blk_q[c]) begin
        ca_d[c].block_done_flag = 1'b0;
        arm_blk_d[c] = 1'b0;
      end
      // Locked enables: a write changes them only where its write-enable bit is set
      if (wr_pend_q && w_is_opc && i_hwdata[`FCDMA_OPC_WE_LSB + c]) begin
        en_d[c] = i_hwdata[`FCDMA_OPC_EN_LSB + c];
        suc_d[c] = i_hwdata[`FCDMA_OPC_SUC_LSB + c];
        if (i_hwdata[`FCDMA_OPC_EN_LSB + c] && !cb_q[c].dma_bus_error_flag) begin
          any_start = 1'b1;
        end
      end
      // One unit moved: count down and step the addresses
      // Pulses are taken even on a stopped channel; the sequencer gates them
      if (i_xfer_pulse[c]) begin
        cnt_d[c] = cnt_q[c] - `FCDMA_CNT_DEC;
        if (ca_q[c].mem_addr_direction) begin
          mem_addr_d[c] = mem_addr_q[c] - step;
        end else begin
          mem_addr_d[c] = mem_addr_q[c] + step;
        end
        if (dual) begin
          if (cb_q[c].dev_addr_step == `FCDMA_STEP_INC) begin
            dev_addr_d[c] = dev_addr_q[c] + step;
          end else if (cb_q[c].dev_addr_step == `FCDMA_STEP_DEC) begin
            dev_addr_d[c] = dev_addr_q[c] - step;
          end
        end
        // A count of zero wraps to the full 64k, so only one ends it
        if (cnt_q[c] == `FCDMA_CNT_LAST) begin
          if (cont && suc_q[c]) begin
            mem_addr_d[c] = dev_addr_q[c];
            cnt_d[c] = ncnt_q[c];
            ncnt_d[c] = cnt_q[c] - `FCDMA_CNT_DEC;
            ca_d[c].mem_space = cb_q[c].dev_space;
            if (!ca_d[c].xfer_done_flag) begin
              ca_d[c].block_done_flag = 1'b1;
            end
          end else begin
            ca_d[c].xfer_done_flag = 1'b1;
            en_d[c] = 1'b0;
          end
        end
      end
      // Completion input ends the whole transfer early
      // It stops the channel the same way a count run-out does
      if (i_done_pulse[c]) begin
        ca_d[c].xfer_done_flag = 1'b1;
        en_d[c] = 1'b0;
      end
      // A fault is charged to the channel that owns the current cycle
      if (i_bus_err && (i_act_ch == 2'(c))) begin
        cb_d[c].dma_bus_error_flag = 1'b1;
      end
    end
    if (any_start) begin
      master_d = 1'b1;
    end
    // Stop wins over start: a fault must always halt every channel
    if (i_nmi || i_bus_err) begin
      master_d = 1'b0;
    end
  end

  // Register the channel state
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        mem_addr_q[c] <= `FCDMA_RST_ADDR;
        dev_addr_q[c] <= `FCDMA_RST_ADDR;
        cnt_q[c] <= `FCDMA_RST_CNT;
        ncnt_q[c] <= `FCDMA_RST_CNT;
        ca_q[c] <= fcdma_ctrl_a_t'(`FCDMA_RST_CTRL);
        cb_q[c] <= fcdma_ctrl_b_t'(`FCDMA_RST_CTRL);
      end
      en_q <= '0;
      suc_q <= '0;
      arm_xfer_q <= '0;
      arm_blk_q <= '0;
      master_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        mem_addr_q[c] <= mem_addr_d[c];
        dev_addr_q[c] <= dev_addr_d[c];
        cnt_q[c] <= cnt_d[c];
        ncnt_q[c] <= ncnt_d[c];
        ca_q[c] <= ca_d[c];
        cb_q[c] <= cb_d[c];
      end
      en_q <= en_d;
      suc_q <= suc_d;
      arm_xfer_q <= arm_xfer_d;
      arm_blk_q <= arm_blk_d;
      master_q <= master_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  // --------------------------------------------------------------------------
  // Read data and outputs
  // --------------------------------------------------------------------------
  // Read data comes from next state so a read right behind a write of the
  // same register sees the new value without a wait state.
  always_comb begin
    hrdata_d = `FCDMA_RST_WORD;
    if (rd_acc && a_is_ch) begin
      unique case (a_reg)
        `FCDMA_REG_MEM: hrdata_d[ADDR_BITS-1:0] = mem_addr_d[a_ch];
        `FCDMA_REG_DEV: hrdata_d[ADDR_BITS-1:0] = dev_addr_d[a_ch];
        `FCDMA_REG_CNT: hrdata_d[15:0] = cnt_d[a_ch];
        `FCDMA_REG_NCNT: hrdata_d[15:0] = ncnt_d[a_ch];
        `FCDMA_REG_CA: hrdata_d[15:0] = ca_d[a_ch];
        `FCDMA_REG_CB: hrdata_d[15:0] = cb_d[a_ch];
        default: hrdata_d = `FCDMA_RST_WORD;
      endcase
    end else if (rd_acc && (i_haddr[7:0] == `FCDMA_OPC_ADDR)) begin
      // Write-enable bits always read back as zero
      hrdata_d[`FCDMA_OPC_EN_LSB +: NUM_CH] = en_d;
      hrdata_d[`FCDMA_OPC_SUC_LSB +: NUM_CH] = suc_d;
      hrdata_d[`FCDMA_OPC_MST_BIT] = master_d;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      // A cleared enable or master pauses the channel in place
      run_d[c] = en_d[c] & master_d;
      auto_d[c] = run_d[c] & (ca_d[c].device_class == `FCDMA_CLS_DUAL_AUTO);
      irq_d[c] = (ca_d[c].block_done_flag & ca_d[c].block_done_irq_en) |
                 (ca_d[c].xfer_done_flag & ca_d[c].xfer_done_irq_en);
    end
    // Space status follows the cycle kind of the active channel
    // Current state is used so the status matches the cycle now on the bus
    space_d = `FCDMA_SPACE_IDLE;
    if (i_dma_cycle) begin
      space_d = i_dev_cycle ? cb_q[i_act_ch].dev_space : ca_q[i_act_ch].mem_space;
    end
    // Addresses of the owning channel, as they will stand after this edge
    mem_out_d = mem_addr_d[i_act_ch];
    dev_out_d = dev_addr_d[i_act_ch];
    // Sense, bus mode and direction are carried out to the sequencer
    cfg_d = ca_d[i_act_ch];
  end

  // Register all outputs
  // Ready never drops: every access finishes without a wait state
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= `FCDMA_RST_WORD;
      o_chan_run <= '0;
      o_auto_req <= '0;
      o_irq <= '0;
      o_space_status <= `FCDMA_SPACE_IDLE;
      o_mem_addr <= `FCDMA_RST_ADDR;
      o_dev_addr <= `FCDMA_RST_ADDR;
      o_act_cfg <= fcdma_ctrl_a_t'(`FCDMA_RST_CTRL);
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= hrdata_d;
      o_chan_run <= run_d;
      o_auto_req <= auto_d;
      o_irq <= irq_d;
      o_space_status <= space_d;
      o_mem_addr <= mem_out_d;
      o_dev_addr <= dev_out_d;
      o_act_cfg <= cfg_d;
    end
  end

endmodule

`default_nettype wire

// [fcdma_checker.sv]
`timescale 1ns/100ps
`default_nettype none

// ----
// Port watcher for the channel control block
// ----
module fcdma_checker #(
  parameter int NUM_CH = 4
) (
  // Bus side
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  // Sequencer side
  input wire logic [NUM_CH-1:0] i_xfer_pulse,
  input wire logic [NUM_CH-1:0] i_done_pulse,
  input wire logic i_dma_cycle,
  input wire logic i_bus_err,
  input wire logic i_nmi,
  input wire logic [NUM_CH-1:0] o_chan_run,
  input wire logic [NUM_CH-1:0] o_auto_req,
  input wire logic [NUM_CH-1:0] o_irq,
  input wire logic [1:0] o_space_status
);
  logic quiet;
  logic rd_req;

  // No bus request and no event: after two such cycles in a row state may not move
  assign quiet = !(i_hsel && i_htrans[1]) && (i_xfer_pulse == '0) && (i_done_pulse == '0)
    && !i_bus_err && !i_nmi;
  // Read address phase taken at this edge
  assign rd_req = i_hsel && i_htrans[1] && i_hready && !i_hwrite;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready or not okay");
  a_rdata_idle: assert property (!$past(rd_req) |-> o_hrdata == 32'h0)
    else $error("read data outside a read data phase");
  a_space_idle: assert property (!$past(i_dma_cycle) |-> o_space_status == 2'h0)
    else $error("space status outside a transfer cycle");
  a_auto_in_run: assert property ((o_auto_req & ~o_chan_run) == '0)
    else $error("auto request on a stopped channel");
  a_nmi_stops: assert property (i_nmi |=> o_chan_run == '0)
    else $error("channel still runs after nmi");
  a_err_stops: assert property (i_bus_err |=> o_chan_run == '0)
    else $error("channel still runs after bus error");
  a_run_quiet: assert property ($past(quiet) && $past(quiet, 2) |-> $stable(o_chan_run))
    else $error("run state moved without cause");
  a_irq_quiet: assert property ($past(quiet) && $past(quiet, 2) |-> $stable(o_irq))
    else $error("interrupt moved without cause");

  c_nmi: cover property (i_nmi);
  c_irq: cover property (o_irq != '0);
  c_auto: cover property (o_auto_req != '0);
endmodule
`default_nettype wire

// [fcdma_defines.svh]
`ifndef FCDMA_DEFINES_SVH
`define FCDMA_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define FCDMA_CH_ADDR_BIT 7
`define FCDMA_OPC_ADDR 8'h80
`define FCDMA_REG_MEM 5'h00
`define FCDMA_REG_DEV 5'h04
`define FCDMA_REG_CNT 5'h08
`define FCDMA_REG_NCNT 5'h0C
`define FCDMA_REG_CA 5'h10
`define FCDMA_REG_CB 5'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FCDMA_OPC_WE_LSB 0
`define FCDMA_OPC_EN_LSB 4
`define FCDMA_OPC_SUC_LSB 8
`define FCDMA_OPC_MST_BIT 15
`define FCDMA_CB_ERR_BIT 15
`define FCDMA_HTRANS_ACTIVE_BIT 1

// ----------------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------------
`define FCDMA_CLS_SINGLE_CONT 3'h1
`define FCDMA_CLS_DUAL_AUTO 3'h7
`define FCDMA_STEP_INC 2'h0
`define FCDMA_STEP_DEC 2'h1
`define FCDMA_STEP_BYTE 24'h000001
`define FCDMA_STEP_WORD 24'h000002
`define FCDMA_CNT_LAST 16'h0001
`define FCDMA_CNT_DEC 16'h0001

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FCDMA_RST_ADDR 24'h000000
`define FCDMA_RST_CNT 16'h0000
`define FCDMA_RST_CTRL 16'h0000
`define FCDMA_RST_WORD 32'h00000000
`define FCDMA_SPACE_IDLE 2'h0

`endif

// [fcdma_pkg.sv]
package fcdma_pkg;

  // Channel control A, most significant bit first
  typedef struct packed {
    logic xfer_done_flag;
    logic xfer_done_irq_en;
    logic block_done_flag;
    logic block_done_irq_en;
    logic prio_express;
    logic direction;
    logic bus_mode_sel;
    logic request_sense;
    logic operand_size_sel;
    logic port_size_sel;
    logic [2:0] device_class;
    logic [1:0] mem_space;
    logic mem_addr_direction;
  } fcdma_ctrl_a_t;

  // Channel control B, most significant bit first
  typedef struct packed {
    logic dma_bus_error_flag;
    logic [10:0] unused;
    logic [1:0] dev_space;
    logic [1:0] dev_addr_step;
  } fcdma_ctrl_b_t;

endpackage

// [fcdma_seq_model.sv]
`timescale 1ns/100ps
`default_nettype none

// ----
// Sequencer and requester model: one transfer per request
// ----
module fcdma_seq_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Channel state and requests
  input wire logic [3:0] i_run,
  input wire logic [3:0] i_auto,
  input wire logic [3:0] i_kick,
  input wire logic i_slow,
  // Towards the block
  output logic [3:0] o_xfer,
  output logic [1:0] o_act,
  output logic o_dma,
  output logic o_dev
);
  logic [3:0] pend_q, nxt, go;
  logic [1:0] ph_q, c;

  // A pulse is only sent while the channel still runs, so a stop drops the pulse of the cycle in flight
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {pend_q, ph_q, o_xfer, o_act, o_dma, o_dev} <= '0;
    end else begin
      nxt = pend_q | i_kick;
      go = i_run & (nxt | i_auto);
      o_xfer <= 4'h0;
      case (ph_q)
        2'h0: if (go != 4'h0) begin
          c = go[0] ? 2'h0 : go[1] ? 2'h1 : go[2] ? 2'h2 : 2'h3;
          nxt[c] = 1'b0;
          o_act <= c;
          o_dma <= 1'b1;
          ph_q <= 2'h1;
        end
        2'h1: begin
          o_dev <= 1'b1;
          ph_q <= i_slow ? 2'h2 : 2'h3;
        end
        2'h2: ph_q <= 2'h3;
        default: begin
          {o_dma, o_dev, ph_q} <= '0;
          if (i_run[o_act]) o_xfer[o_act] <= 1'b1;
        end
      endcase
      pend_q <= nxt;
    end
  end
endmodule
`default_nettype wire

// [four_channel_dma_channel_control_tb.sv]
`include "fcdma_defines.svh"
`timescale 1ns/100ps
`default_nettype none

// ----
// Bench
// ----
module four_channel_dma_channel_control_tb;
  import fcdma_pkg::*;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, berr = 0, nmi = 0, slow = 0;
  logic hrdy, hresp, dma, dev;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, act, space;
  logic [3:0] xfer, done = 0, kick = 0, run, auto, irq;
  logic [23:0] maddr, daddr;
  fcdma_ctrl_a_t cfg;
  int n_errors = 0, checked = 0, cyc = 0;

  always #20 clk = ~clk;

  fcdma_channel_ctrl fcdma_channel_ctrl_inst (.i_core_clk(clk), .i_sys_rst(rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_xfer_pulse(xfer), .i_done_pulse(done), .i_act_ch(act), .i_dma_cycle(dma),
    .i_dev_cycle(dev), .i_bus_err(berr), .i_nmi(nmi), .o_chan_run(run), .o_auto_req(auto),
    .o_irq(irq), .o_space_status(space), .o_mem_addr(maddr), .o_dev_addr(daddr),
    .o_act_cfg(cfg));

  fcdma_seq_model fcdma_seq_model_inst (.i_clk(clk), .i_rst(rst), .i_run(run), .i_auto(auto),
    .i_kick(kick), .i_slow(slow), .o_xfer(xfer), .o_act(act), .o_dma(dma), .o_dev(dev));

  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask

  // Single word transfer; each phase ends at an edge that sees ready high,
  // and read data is taken at the edge that closes the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(w, e, rd);
  endtask

  function automatic logic [7:0] ra(input logic [1:0] c, input logic [4:0] o);
    return {1'b0, c, o};
  endfunction

  // Address after n units: 0 up, 1 down, else held
  function automatic logic [23:0] stepped(input logic [31:0] a, input logic [1:0] m, input int n);
    return (m == 2'h0) ? 24'(a + n) : (m == 2'h1) ? 24'(a - n) : a[23:0];
  endfunction

  initial begin
    logic [1:0] c, ms, dsp, dst;
    logic [31:0] v, a0, d0;
    int n, st;
    void'($urandom(27));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("ctrl a", ra(0, `FCDMA_REG_CA), 0);
    rchk("opc", `FCDMA_OPC_ADDR, 0);
    bus(1, 8'h98, '1);
    rchk("unmapped", 8'h98, 0);
    // Every legal class with random plain bits
    for (int i = 0; i < 8; i++) begin
      if (i == 2 || i == 3) continue;
      v = ($urandom & 32'h5FC7) | (i << 3);
      bus(1, ra(i[1:0], `FCDMA_REG_CA), v);
      rchk("ctrl a", ra(i[1:0], `FCDMA_REG_CA), v);
      bus(1, ra(i[1:0], `FCDMA_REG_CA), 0);
    end
    c = 2'($urandom);
    v = $urandom;
    bus(1, ra(c, `FCDMA_REG_MEM), v);
    rchk("mem addr", ra(c, `FCDMA_REG_MEM), v & 32'hFFFFFF);
    bus(1, ra(c, `FCDMA_REG_DEV), v);
    rchk("dev addr", ra(c, `FCDMA_REG_DEV), v & 32'hFFFFFF);
    bus(1, ra(c, `FCDMA_REG_CNT), v);
    rchk("count", ra(c, `FCDMA_REG_CNT), v & 32'hFFFF);
    bus(1, `FCDMA_OPC_ADDR, 32'h10 << c);
    rchk("opc", `FCDMA_OPC_ADDR, 0);
    bus(1, `FCDMA_OPC_ADDR, 32'h11 << c);
    rchk("opc", `FCDMA_OPC_ADDR, (32'h10 << c) | 32'h8000);
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    rchk("opc", `FCDMA_OPC_ADDR, 32'h10 << c);
    bus(1, `FCDMA_OPC_ADDR, 32'h1 << c);
    // Dual auto blocks, prompt and slow sequencer
    for (int k = 0; k < 4; k++) begin
      c = 2'($urandom);
      n = 2 + $urandom % 4;
      ms = 2'($urandom);
      dsp = 2'($urandom);
      dst = 2'($urandom % 3);
      v = 32'h4038 | ($urandom & 32'hC1) | (ms << 1);
      st = (v[6] || v[7]) ? 1 : 2;
      a0 = $urandom & 32'hFFFFFF;
      d0 = $urandom & 32'hFFFFFF;
      slow <= k[0];
      bus(1, ra(c, `FCDMA_REG_MEM), a0);
      bus(1, ra(c, `FCDMA_REG_DEV), d0);
      bus(1, ra(c, `FCDMA_REG_CNT), n);
      bus(1, ra(c, `FCDMA_REG_CB), {dsp, dst});
      bus(1, ra(c, `FCDMA_REG_CA), v);
      bus(1, `FCDMA_OPC_ADDR, 32'h11 << c);
      for (int t = 0; t < 99 && !(dma && !dev); t++) @(negedge clk);
      @(negedge clk);
      chk("mem space", ms, space);
      @(negedge clk);
      chk("dev space", dsp, space);
      for (int t = 0; t < 300 && run[c]; t++) @(negedge clk);
      repeat (6) @(posedge clk);
      chk("irq", 1, irq[c]);
      chk("mem out", stepped(a0, {1'b0, v[0]}, n * st), maddr);
      chk("dev out", stepped(d0, dst, n * st), daddr);
      chk("cfg out", v | 32'h8000, cfg);
      // Control A is read first: an arm left by an earlier read would
      // otherwise let the counter read clear the done flag too soon
      rchk("ctrl a", ra(c, `FCDMA_REG_CA), v | 32'h8000);
      rchk("count", ra(c, `FCDMA_REG_CNT), 0);
      rchk("mem addr", ra(c, `FCDMA_REG_MEM), stepped(a0, {1'b0, v[0]}, n * st));
      rchk("dev addr", ra(c, `FCDMA_REG_DEV), stepped(d0, dst, n * st));
      rchk("opc", `FCDMA_OPC_ADDR, 32'h8000);
      rchk("count", ra(c, `FCDMA_REG_CNT), 0);
      rchk("ctrl a", ra(c, `FCDMA_REG_CA), v);
      chk("irq", 0, irq[c]);
      bus(1, ra(c, `FCDMA_REG_CA), 0);
    end
    // Continue block end swaps in the next block
    c = 2'($urandom);
    a0 = $urandom & 32'hFFFFFF;
    n = 3 + $urandom % 9;
    bus(1, ra(c, `FCDMA_REG_DEV), a0);
    bus(1, ra(c, `FCDMA_REG_CNT), 1);
    bus(1, ra(c, `FCDMA_REG_NCNT), n);
    bus(1, ra(c, `FCDMA_REG_CB), dsp << 2);
    bus(1, ra(c, `FCDMA_REG_CA), 32'h1008);
    bus(1, `FCDMA_OPC_ADDR, 32'h111 << c);
    kick <= 4'h1 << c;
    @(posedge clk);
    kick <= 4'h0;
    for (int t = 0; t < 99 && !xfer[c]; t++) @(negedge clk);
    repeat (3) @(posedge clk);
    chk("irq", 1, irq[c]);
    rchk("mem addr", ra(c, `FCDMA_REG_MEM), a0);
    rchk("count", ra(c, `FCDMA_REG_CNT), n);
    rchk("opc", `FCDMA_OPC_ADDR, (32'h110 << c) | 32'h8000);
    rchk("ctrl a", ra(c, `FCDMA_REG_CA), 32'h3008 | (dsp << 1));
    rchk("next count", ra(c, `FCDMA_REG_NCNT), 0);
    rchk("ctrl a", ra(c, `FCDMA_REG_CA), 32'h1008 | (dsp << 1));
    // Bus error on the owning channel locks the master enable
    berr <= 1'b1;
    @(posedge clk);
    berr <= 1'b0;
    bus(1, ra(c, `FCDMA_REG_CB), dsp << 2);
    rchk("ctrl b", ra(c, `FCDMA_REG_CB), 32'h8000 | (dsp << 2));
    bus(1, `FCDMA_OPC_ADDR, 32'h11 << c);
    rchk("opc", `FCDMA_OPC_ADDR, 32'h10 << c);
    bus(1, ra(c, `FCDMA_REG_CB), 32'h8000);
    rchk("ctrl b", ra(c, `FCDMA_REG_CB), 0);
    bus(1, `FCDMA_OPC_ADDR, 32'h11 << c);
    rchk("opc", `FCDMA_OPC_ADDR, (32'h10 << c) | 32'h8000);
    bus(1, `FCDMA_OPC_ADDR, 32'h1 << c);
    // Completion input ends a transfer early
    c = 2'($urandom);
    bus(1, ra(c, `FCDMA_REG_CNT), 5);
    bus(1, ra(c, `FCDMA_REG_CA), 32'h4000);
    bus(1, `FCDMA_OPC_ADDR, 32'h11 << c);
    done <= 4'h1 << c;
    @(posedge clk);
    done <= 4'h0;
    repeat (2) @(posedge clk);
    rchk("ctrl a", ra(c, `FCDMA_REG_CA), 32'hC000);
    rchk("opc", `FCDMA_OPC_ADDR, 32'h8000);
    wrap_up();
  end
endmodule

bind fcdma_channel_ctrl fcdma_checker #(.NUM_CH(NUM_CH)) fcdma_checker_inst (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_hrdata(o_hrdata), .i_xfer_pulse(i_xfer_pulse), .i_done_pulse(i_done_pulse),
  .i_dma_cycle(i_dma_cycle), .i_bus_err(i_bus_err), .i_nmi(i_nmi), .o_chan_run(o_chan_run),
  .o_auto_req(o_auto_req), .o_irq(o_irq), .o_space_status(o_space_status));
`default_nettype wire
